/* pmsc_pkg.sv */
// pmsc_pkg: constants, register map and state types of the module sideband control.
// assumes a 20 MHz system clock; the link side runs on the host's serial clock.
package pmsc_pkg;
   // timing
   localparam int unsigned CLK_PERIOD_NS = 50;
   localparam int unsigned INIT_TIME_MS = 2000;
   localparam int unsigned RESET_MIN_NS = 10000;
   localparam int unsigned INIT_CNT_W = 26;
   localparam int unsigned RST_CNT_W = 16;
   // longest time rounds down, least time rounds up
   localparam logic [INIT_CNT_W-1:0] INIT_CYC_DEF =
      INIT_CNT_W'((INIT_TIME_MS * 1000000) / CLK_PERIOD_NS);
   localparam logic [RST_CNT_W-1:0] RESET_MIN_CYC_DEF =
      RST_CNT_W'((RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   // sizes
   localparam int unsigned NUM_CH = 4;
   localparam int unsigned NUM_REG = 4;
   localparam int unsigned DATA_W = 8;
   localparam int unsigned NUM_SYNC = 3;
   // serial bus address, value is arbitrary
   localparam logic [6:0] DEV_ADDR = 7'h50;
   // register offsets
   localparam logic [7:0] REG_STATUS = 8'h00;
   localparam logic [7:0] REG_FLAGS = 8'h01;
   localparam logic [7:0] REG_CHAN_DIS = 8'h02;
   localparam logic [7:0] REG_POWER = 8'h03;
   // field positions
   localparam int unsigned ST_NOT_READY = 0;
   localparam int unsigned ST_LP_PIN = 1;
   localparam int unsigned ST_POWER_CAP = 2;
   localparam int unsigned ST_ATTN = 3;
   localparam int unsigned FL_DONE = 0;
   localparam int unsigned FL_FAULT_LSB = 4;
   localparam int unsigned PW_SW_LP = 0;
   // reset values
   localparam logic [NUM_CH-1:0] CHAN_DIS_RST = 4'h0;
   localparam logic SW_LP_RST = 1'b0;
   // synchroniser order and reset levels: reset pin, low-power pin, write toggle
   localparam int unsigned SY_RST = 0;
   localparam int unsigned SY_LP = 1;
   localparam int unsigned SY_WR = 2;
   localparam logic [NUM_SYNC-1:0] SYNC_RST = 3'h1;
   typedef enum logic [3:0] {
      LK_IDLE, LK_ADDR, LK_ADDR_ACK, LK_PTR, LK_PTR_ACK,
      LK_WDATA, LK_WDATA_ACK, LK_RDATA, LK_RDATA_ACK
   } pmsc_link_state_t;
   typedef enum logic [1:0] {CTL_INIT, CTL_RUN, CTL_HOLD} pmsc_ctl_state_t;
endpackage : pmsc_pkg

/* pmsc_serial_slave.sv */
// pmsc_serial_slave: two-wire serial slave running on the host's serial clock.
// assumes the map input is quasi-static and link_rst_i comes from a flop of the system clock.
`timescale 1ns/100ps
module pmsc_serial_slave import pmsc_pkg::*; (
   // link
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_oe_o,
   // control from system side
   input wire logic link_rst_i,
   input wire logic module_select_n_i,
   input wire logic [NUM_REG*DATA_W-1:0] map_i,
   // write event towards system side
   output logic wr_tgl_o,
   output logic [7:0] wr_addr_o,
   output logic [7:0] wr_data_o
);
   // read decode, used for first and following bytes
   function automatic logic [7:0] rd_byte(input logic [7:0] a, input logic [NUM_REG*DATA_W-1:0] m);
      rd_byte = 8'h00;
      if (a < 8'(NUM_REG)) begin
         rd_byte = m[a[1:0]*DATA_W +: DATA_W];
      end
   endfunction : rd_byte

   logic start_tgl_q, start_tgl_d;
   pmsc_link_state_t state_q, state_d;
   logic [2:0] cnt_q, cnt_d;
   logic [7:0] sh_q, sh_d, tx_q, tx_d, ptr_q, ptr_d, wa_q, wa_d, wd_q, wd_d;
   logic seen_q, seen_d, rw_q, rw_d, tgl_q, tgl_d, oe_q, oe_d;
   logic last;

   // start: data falls while clock is high; clock is idle between frames
   always_comb start_tgl_d = scl_i ? ~start_tgl_q : start_tgl_q;
   always_ff @(negedge sda_i or posedge link_rst_i) begin
      if (link_rst_i) start_tgl_q <= 1'b0;
      else start_tgl_q <= start_tgl_d;
   end

   // bit sampling on the rising clock edge
   always_comb begin
      state_d = state_q;
      cnt_d = cnt_q + 3'h1;
      sh_d = {sh_q[6:0], sda_i};
      tx_d = tx_q;
      ptr_d = ptr_q;
      wa_d = wa_q;
      wd_d = wd_q;
      rw_d = rw_q;
      tgl_d = tgl_q;
      seen_d = start_tgl_q;
      last = (cnt_q == 3'h7);
      if (start_tgl_q != seen_q) begin
         state_d = LK_ADDR;
         cnt_d = 3'h1;
      end else if (module_select_n_i) begin
         state_d = LK_IDLE; // deselected mid-frame: drop off the bus
      end else begin
         case (state_q)
            LK_IDLE: state_d = LK_IDLE;
            LK_ADDR: if (last) begin
               state_d = LK_IDLE;
               if (sh_q[6:0] == DEV_ADDR) begin // select checked above
                  rw_d = sda_i;
                  state_d = LK_ADDR_ACK;
               end
            end
            LK_ADDR_ACK: begin
               cnt_d = 3'h0;
               state_d = rw_q ? LK_RDATA : LK_PTR;
               tx_d = rd_byte(ptr_q, map_i);
            end
            LK_PTR: if (last) begin
               ptr_d = sh_d;
               state_d = LK_PTR_ACK;
            end
            LK_PTR_ACK: begin
               cnt_d = 3'h0;
               state_d = LK_WDATA;
            end
            LK_WDATA: if (last) begin
               wa_d = ptr_q; // address and data held until the next byte
               wd_d = sh_d;
               tgl_d = ~tgl_q;
               ptr_d = ptr_q + 8'h01;
               state_d = LK_WDATA_ACK;
            end
            LK_WDATA_ACK: begin
               cnt_d = 3'h0;
               state_d = LK_WDATA;
            end
            LK_RDATA: begin
               tx_d = {tx_q[6:0], 1'b0};
               if (last) begin
                  ptr_d = ptr_q + 8'h01;
                  state_d = LK_RDATA_ACK;
               end
            end
            LK_RDATA_ACK: begin
               cnt_d = 3'h0;
               state_d = LK_IDLE; // master nack ends the read
               if (!sda_i) begin
                  state_d = LK_RDATA;
                  tx_d = rd_byte(ptr_q, map_i);
               end
            end
            default: state_d = LK_IDLE;
         endcase
      end
   end
   always_ff @(posedge scl_i or posedge link_rst_i) begin
      if (link_rst_i) begin
         state_q <= LK_IDLE;
         cnt_q <= 3'h0;
         sh_q <= 8'h00;
         tx_q <= 8'h00;
         ptr_q <= 8'h00;
         wa_q <= 8'h00;
         wd_q <= 8'h00;
         rw_q <= 1'b0;
         tgl_q <= 1'b0;
         seen_q <= 1'b0;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         sh_q <= sh_d;
         tx_q <= tx_d;
         ptr_q <= ptr_d;
         wa_q <= wa_d;
         wd_q <= wd_d;
         rw_q <= rw_d;
         tgl_q <= tgl_d;
         seen_q <= seen_d;
      end
   end

   // data changes only on the falling clock edge; only pulls low
   always_comb begin
      case (state_q)
         LK_ADDR_ACK, LK_PTR_ACK, LK_WDATA_ACK: oe_d = 1'b1;
         LK_RDATA: oe_d = ~tx_q[7];
         default: oe_d = 1'b0;
      endcase
   end
   always_ff @(negedge scl_i or posedge link_rst_i) begin
      if (link_rst_i) oe_q <= 1'b0;
      else oe_q <= oe_d;
   end

   assign sda_oe_o = oe_q;
   assign wr_tgl_o = tgl_q;
   assign wr_addr_o = wa_q;
   assign wr_data_o = wd_q;
endmodule : pmsc_serial_slave

/* pmsc_top.sv */
// pmsc_top: low-speed sideband and management control of a four-lane pluggable module.
// assumes a 20 MHz clock; serial clock and data come from the host, pull-ups sit on the host.
`timescale 1ns/100ps
module pmsc_top import pmsc_pkg::*; #(
   parameter logic [RST_CNT_W-1:0] MIN_RESET_CYC = RESET_MIN_CYC_DEF,
   parameter logic [INIT_CNT_W-1:0] INIT_CYC = INIT_CYC_DEF
) (
   // system
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic ce_i,
   // two-wire serial link
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_o,
   // sideband pins
   input wire logic module_select_n_i,
   input wire logic module_reset_n_i,
   input wire logic low_power_request_i,
   output logic module_present_n_o,
   output logic attention_n_o,
   output logic attention_oe_o,
   // module core
   input wire logic [NUM_CH-1:0] chan_fault_i,
   output logic [NUM_CH-1:0] chan_disable_o,
   output logic power_cap_o,
   output logic not_ready_o
);
   logic [NUM_SYNC-1:0] sync_in, lvl;
   logic wr_tgl;
   logic [7:0] wr_addr, wr_data;
   logic [NUM_REG*DATA_W-1:0] map;
   logic link_oe;

   pmsc_ctl_state_t state_q, state_d;
   logic [RST_CNT_W-1:0] low_cnt_q, low_cnt_d;
   logic [INIT_CNT_W-1:0] init_cnt_q, init_cnt_d;
   logic not_ready_q, not_ready_d;
   logic done_q, done_d;
   logic [NUM_CH-1:0] fault_q, fault_d;
   logic [NUM_CH-1:0] chan_dis_q, chan_dis_d;
   logic sw_lp_q, sw_lp_d;
   logic wr_seen_q, wr_seen_d;
   logic att_oe_q, att_oe_d;
   logic cap_q, cap_d;
   logic [NUM_CH-1:0] ch_out_q, ch_out_d;
   logic link_rst_q, link_rst_d;
   logic sda_oe_q;
   logic present_q;
   logic qualified, wr_evt;

   assign sync_in[SY_RST] = module_reset_n_i;
   assign sync_in[SY_LP] = low_power_request_i;
   assign sync_in[SY_WR] = wr_tgl;

   // three-stage synchronisers; a level is taken once stages two and three agree
   for (genvar g = 0; g < NUM_SYNC; g++) begin : g_sync
      logic [2:0] s_q, s_d;
      logic l_q, l_d;
      always_comb begin
         s_d = {s_q[1:0], sync_in[g]};
         l_d = (s_q[1] == s_q[2]) ? s_q[2] : l_q;
      end
      always_ff @(posedge clk_i) begin
         if (!rst_n_i) begin
            s_q <= {3{SYNC_RST[g]}};
            l_q <= SYNC_RST[g];
         end else if (ce_i) begin
            s_q <= s_d;
            l_q <= l_d;
         end
      end
      assign lvl[g] = l_q;
   end

   // serial slave on the host's clock; it is held in reset while the module resets
   pmsc_serial_slave u_link (
      .scl_i(scl_i),
      .sda_i(sda_i),
      .sda_oe_o(link_oe),
      .link_rst_i(link_rst_q),
      .module_select_n_i(module_select_n_i),
      .map_i(map),
      .wr_tgl_o(wr_tgl),
      .wr_addr_o(wr_addr),
      .wr_data_o(wr_data)
   );

   // read map built from flops only; a byte may straddle an update, the host rereads
   always_comb begin
      map = '0;
      map[REG_STATUS[1:0]*DATA_W + ST_NOT_READY] = not_ready_q;
      map[REG_STATUS[1:0]*DATA_W + ST_LP_PIN] = lvl[SY_LP];
      map[REG_STATUS[1:0]*DATA_W + ST_POWER_CAP] = cap_q;
      map[REG_STATUS[1:0]*DATA_W + ST_ATTN] = att_oe_q;
      map[REG_FLAGS[1:0]*DATA_W + FL_DONE] = done_q;
      map[REG_FLAGS[1:0]*DATA_W + FL_FAULT_LSB +: NUM_CH] = fault_q;
      map[REG_CHAN_DIS[1:0]*DATA_W +: NUM_CH] = chan_dis_q;
      map[REG_POWER[1:0]*DATA_W + PW_SW_LP] = sw_lp_q;
   end

   // reset pin qualification: only a low longer than the minimum counts
   always_comb begin
      low_cnt_d = 16'h0000;
      if (!lvl[SY_RST]) begin
         low_cnt_d = (low_cnt_q > MIN_RESET_CYC) ? low_cnt_q : low_cnt_q + 16'h0001;
      end
   end
   assign qualified = low_cnt_q > MIN_RESET_CYC;

   // write event: toggle crossed from the link clock; address and data are stable by then
   assign wr_evt = (lvl[SY_WR] != wr_seen_q);

   // control: init timer, module reset, register writes and event flags
   always_comb begin
      state_d = state_q;
      init_cnt_d = init_cnt_q;
      not_ready_d = not_ready_q;
      done_d = done_q;
      fault_d = fault_q | chan_fault_i;
      chan_dis_d = chan_dis_q;
      sw_lp_d = sw_lp_q;
      wr_seen_d = lvl[SY_WR];
      if (wr_evt) begin
         case (wr_addr)
            REG_FLAGS: begin
               // write one to clear; a fault in the same cycle wins
               fault_d = (fault_q & ~wr_data[FL_FAULT_LSB +: NUM_CH]) | chan_fault_i;
               done_d = done_q & ~wr_data[FL_DONE];
            end
            REG_CHAN_DIS: chan_dis_d = wr_data[NUM_CH-1:0];
            REG_POWER: sw_lp_d = wr_data[PW_SW_LP];
            default: ; // read-only or unmapped: ignored
         endcase
      end
      case (state_q)
         CTL_INIT: begin
            init_cnt_d = init_cnt_q + 26'h000_0001;
            if (init_cnt_q >= INIT_CYC - 26'h000_0001) begin
               not_ready_d = 1'b0;
               done_d = 1'b1; // completion attention, also after power-up
               state_d = CTL_RUN;
            end
         end
         CTL_RUN: state_d = CTL_RUN;
         CTL_HOLD: begin
            init_cnt_d = 26'h000_0000;
            if (lvl[SY_RST]) state_d = CTL_INIT;
         end
         default: state_d = CTL_INIT;
      endcase
      if (qualified) begin
         // every setting back to default while the pin stays low
         state_d = CTL_HOLD;
         init_cnt_d = 26'h000_0000;
         not_ready_d = 1'b1;
         done_d = 1'b0;
         fault_d = '0;
         chan_dis_d = CHAN_DIS_RST;
         sw_lp_d = SW_LP_RST;
      end
   end

   // output flops are fed from next values so they follow state in the same cycle
   always_comb begin
      att_oe_d = done_d | (|fault_d);
      cap_d = lvl[SY_LP] | sw_lp_d;
      ch_out_d = chan_dis_d | {NUM_CH{not_ready_d}}; // lanes stay off until ready
      link_rst_d = (state_d == CTL_HOLD);
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         state_q <= CTL_INIT; // power-up runs the init timer by itself
         low_cnt_q <= 16'h0000;
         init_cnt_q <= 26'h000_0000;
         not_ready_q <= 1'b1;
         done_q <= 1'b0;
         fault_q <= '0;
         chan_dis_q <= CHAN_DIS_RST;
         sw_lp_q <= SW_LP_RST;
         wr_seen_q <= 1'b0;
         att_oe_q <= 1'b0;
         cap_q <= 1'b0;
         ch_out_q <= {NUM_CH{1'b1}};
         link_rst_q <= 1'b1;
      end else if (ce_i) begin
         state_q <= state_d;
         low_cnt_q <= low_cnt_d;
         init_cnt_q <= init_cnt_d;
         not_ready_q <= not_ready_d;
         done_q <= done_d;
         fault_q <= fault_d;
         chan_dis_q <= chan_dis_d;
         sw_lp_q <= sw_lp_d;
         wr_seen_q <= wr_seen_d;
         att_oe_q <= att_oe_d;
         cap_q <= cap_d;
         ch_out_q <= ch_out_d;
         link_rst_q <= link_rst_d;
      end
   end

   // serial data driver; retimed so the pin comes from a flop, one system clock late
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) sda_oe_q <= 1'b0;
      else if (ce_i) sda_oe_q <= link_oe; // frozen with the rest while enable is low
   end

   // presence strap: held low from reset onward
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) present_q <= 1'b0;
      else if (ce_i) present_q <= 1'b0;
   end

   assign sda_o = 1'b0;
   assign sda_oe_o = sda_oe_q;
   assign module_present_n_o = present_q;
   assign attention_n_o = 1'b0; // only ever pulls low; host pull-up releases it
   assign attention_oe_o = att_oe_q;
   assign chan_disable_o = ch_out_q;
   assign power_cap_o = cap_q;
   assign not_ready_o = not_ready_q;
endmodule : pmsc_top

/* pmsc_props.sv */
// pmsc_props: assertion checker for the sideband control top.
// assumes one clk_i domain on the watched side; bound onto every pmsc_top.
`timescale 1ns/100ps
module pmsc_props import pmsc_pkg::*; #(
   parameter logic [RST_CNT_W-1:0] MIN_RESET_CYC = RESET_MIN_CYC_DEF,
   parameter logic [INIT_CNT_W-1:0] INIT_CYC = INIT_CYC_DEF
) (
   // system
   input wire logic clk_i,
   input wire logic rst_n_i,
   // pins
   input wire logic sda_oe_o,
   input wire logic module_select_n_i,
   input wire logic module_reset_n_i,
   input wire logic low_power_request_i,
   input wire logic module_present_n_o,
   input wire logic attention_n_o,
   input wire logic attention_oe_o,
   // module core
   input wire logic [NUM_CH-1:0] chan_fault_i,
   input wire logic [NUM_CH-1:0] chan_disable_o,
   input wire logic power_cap_o,
   input wire logic not_ready_o
);
   int lo_q, lo_d, nr_q, nr_d;
   logic pin_q;
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   // length of the last reset-pin low run, held while high so late entries still see it
   always_comb begin
      lo_d = module_reset_n_i ? lo_q : (pin_q ? 1 : lo_q + 1);
      nr_d = (not_ready_o && module_reset_n_i) ? nr_q + 1 : 0;
   end
   // register the helpers
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         lo_q <= 0;
         nr_q <= 0;
         pin_q <= 1'b1;
      end else begin
         lo_q <= lo_d;
         nr_q <= nr_d;
         pin_q <= module_reset_n_i;
      end
   end
   a_present_low: assert property (module_present_n_o == 1'b0)
      else $error("presence line not low");
   a_attn_drain: assert property (attention_n_o == 1'b0)
      else $error("attention drives high");
   a_select_gate: assert property (sda_oe_o |-> !module_select_n_i)
      else $error("data driven while deselected");
   a_ready_attn: assert property ($fell(not_ready_o) |-> attention_oe_o)
      else $error("ready without attention");
   a_lanes_held: assert property ($past(not_ready_o) && not_ready_o |-> chan_disable_o == 4'hf)
      else $error("lanes on while not ready");
   a_lp_cap: assert property (low_power_request_i [*6] |-> power_cap_o)
      else $error("power not capped");
   a_self_ready: assert property (nr_q <= INIT_CYC + 8)
      else $error("init too long");
   a_long_reset: assert property (!module_reset_n_i && lo_q == MIN_RESET_CYC + 8 |-> not_ready_o)
      else $error("long reset ignored");
   a_short_ignored: assert property ($rose(not_ready_o) |-> lo_q > MIN_RESET_CYC)
      else $error("short reset taken");
   a_fault_attn: assert property ((|chan_fault_i) && !not_ready_o |-> ##[1:3] attention_oe_o)
      else $error("fault not flagged");
   // main scenarios reached
   c_ready: cover property ($fell(not_ready_o));
   c_ack: cover property (sda_oe_o);
   c_fault: cover property ((|chan_fault_i) && !not_ready_o);
endmodule : pmsc_props

bind pmsc_top pmsc_props #(.MIN_RESET_CYC(MIN_RESET_CYC), .INIT_CYC(INIT_CYC)) props_u (
   .clk_i(clk_i), .rst_n_i(rst_n_i), .sda_oe_o(sda_oe_o),
   .module_select_n_i(module_select_n_i), .module_reset_n_i(module_reset_n_i),
   .low_power_request_i(low_power_request_i), .module_present_n_o(module_present_n_o),
   .attention_n_o(attention_n_o), .attention_oe_o(attention_oe_o),
   .chan_fault_i(chan_fault_i), .chan_disable_o(chan_disable_o),
   .power_cap_o(power_cap_o), .not_ready_o(not_ready_o)
);

/* pmsc_host.sv */
// pmsc_host: behavioural host controller on the two-wire bus and the select line.
// assumes a pull-up on the data wire outside; the serial clock stands high between frames.
`timescale 1ns/100ps
module pmsc_host import pmsc_pkg::*; (
   // serial link
   output logic scl_o,
   output logic sda_pull_o,
   input wire logic sda_i,
   // sideband
   output logic select_n_o
);
   localparam int QTR = 40;
   // bus idle: clock high, data released, nobody selected
   initial begin
      scl_o = 1'b1;
      sda_pull_o = 1'b0;
      select_n_o = 1'b1;
   end
   // one bit slot of 160 ns; data moves only while the clock is low
   task automatic bit_io(input logic b, output logic r);
      sda_pull_o = !b;
      #QTR scl_o = 1'b1;
      #QTR r = sda_i;
      #QTR scl_o = 1'b0;
      #QTR;
   endtask : bit_io
   // start, also used as repeated start
   task automatic start_cond();
      sda_pull_o = 1'b0;
      #QTR scl_o = 1'b1;
      #QTR sda_pull_o = 1'b1;
      #QTR scl_o = 1'b0;
      #QTR;
   endtask : start_cond
   task automatic stop_cond();
      sda_pull_o = 1'b1;
      #QTR scl_o = 1'b1;
      #QTR sda_pull_o = 1'b0;
      #QTR;
   endtask : stop_cond
   // eight bits msb first, then the acknowledge slot
   task automatic byte_io(input logic [7:0] tx, output logic [7:0] rx, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(tx[i], r);
         rx[i] = r;
      end
      bit_io(1'b1, r);
      ack = !r;
   endtask : byte_io
   task automatic write_reg(input logic sel_n, input logic [7:0] ptr, input logic [7:0] data,
                            output logic ok);
      logic [7:0] rx;
      logic a0, a1, a2;
      select_n_o = sel_n;
      #200;
      start_cond();
      byte_io({DEV_ADDR, 1'b0}, rx, a0);
      byte_io(ptr, rx, a1);
      byte_io(data, rx, a2);
      stop_cond();
      #200 select_n_o = 1'b1;
      ok = a0 & a1 & a2;
   endtask : write_reg
   // pointer write, repeated start, one byte read and a closing no-ack
   task automatic read_reg(input logic [7:0] ptr, output logic [7:0] data, output logic ok);
      logic [7:0] rx;
      logic a0, a1, a2, a3;
      select_n_o = 1'b0;
      #200;
      start_cond();
      byte_io({DEV_ADDR, 1'b0}, rx, a0);
      byte_io(ptr, rx, a1);
      start_cond();
      byte_io({DEV_ADDR, 1'b1}, rx, a2);
      byte_io(8'hff, data, a3);
      stop_cond();
      #200 select_n_o = 1'b1;
      ok = a0 & a1 & a2;
   endtask : read_reg
endmodule : pmsc_host

/* pmsc_top_bench.sv */
// pmsc_top_bench: self-checking bench of the sideband control with a host model.
// assumes shortened init and reset counts; the host pulls up the open-drain data line only.
`timescale 1ns/100ps
module pmsc_top_bench import pmsc_pkg::*;;
   typedef struct packed {
      logic [7:0] ptr;
      logic [7:0] wd;
      logic [7:0] rd;
      logic [7:0] cd;
      logic cap;
   } pmsc_row_t;
   localparam int MIN_R = 8;
   localparam int INIT_R = 100;
   logic clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic mod_rst_n = 1'b1;
   logic lp_req = 1'b0;
   logic [3:0] fault = 4'h0;
   logic [3:0] chan_dis;
   logic scl, pull, sel_n, sda_oe, present_n, attn_n, attn_oe, cap, nrdy, ok, sda_w, sda_d;
   logic [7:0] d;
   int miscompares = 0;
   int tests_run = 0;
   pmsc_row_t rows [7] = '{
      '{8'h02, 8'h05, 8'h05, 8'h05, 1'b0}, '{8'h02, 8'h0a, 8'h0a, 8'h0a, 1'b0},
      '{8'h03, 8'h01, 8'h01, 8'h0a, 1'b1}, '{8'h03, 8'h00, 8'h00, 8'h0a, 1'b0},
      '{8'h00, 8'hff, 8'h08, 8'h0a, 1'b0}, '{8'h07, 8'h55, 8'h00, 8'h0a, 1'b0},
      '{8'h02, 8'h00, 8'h00, 8'h00, 1'b0}};
   // host pull-up resolves the data wire
   assign sda_w = !(pull | sda_oe);
   always #25 clk_i = !clk_i;
   pmsc_host host_u (.scl_o(scl), .sda_pull_o(pull), .sda_i(sda_w), .select_n_o(sel_n));
   pmsc_top #(.MIN_RESET_CYC(16'(MIN_R)), .INIT_CYC(26'(INIT_R))) dut_u (
      .clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(1'b1), .scl_i(scl), .sda_i(sda_w), .sda_o(sda_d),
      .sda_oe_o(sda_oe), .module_select_n_i(sel_n), .module_reset_n_i(mod_rst_n),
      .low_power_request_i(lp_req), .module_present_n_o(present_n), .attention_n_o(attn_n),
      .attention_oe_o(attn_oe), .chan_fault_i(fault), .chan_disable_o(chan_dis),
      .power_cap_o(cap), .not_ready_o(nrdy));
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : complete_run
   task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH at %0t: value %h expected %h", $time, got, exp);
      end
   endtask : chk_byte
   task automatic chk_bit(input logic got, input logic exp);
      chk_byte({7'h00, got}, {7'h00, exp});
   endtask : chk_bit
   // inputs set after wait_clk move 2 ns after the rising edge
   task automatic wait_clk(input int n);
      repeat (n) @(posedge clk_i);
      #2;
   endtask : wait_clk
   // bounded wait for the init timer to finish
   task automatic wait_ready();
      int n;
      n = 0;
      while (nrdy !== 1'b0 && n < 400) begin
         wait_clk(1);
         n++;
      end
      if (n == 400) begin
         miscompares++;
         $display("MISMATCH at %0t: ready never came", $time);
         complete_run();
      end
   endtask : wait_ready
   task automatic wr(input logic [7:0] ptr, input logic [7:0] v);
      host_u.write_reg(1'b0, ptr, v, ok);
      wait_clk(8);
   endtask : wr
   initial begin
      wait_clk(10);
      rst_n_i = 1'b1;
      chk_bit(present_n, 1'b0);
      chk_bit(attn_n, 1'b0);
      chk_bit(sda_d, 1'b0);
      chk_byte({4'h0, chan_dis}, 8'h0f);
      wait_ready();
      chk_bit(attn_oe, 1'b1);
      foreach (rows[i]) begin
         host_u.write_reg(1'b0, rows[i].ptr, rows[i].wd, ok);
         chk_bit(ok, 1'b1);
         wait_clk(8);
         chk_byte({4'h0, chan_dis}, rows[i].cd);
         chk_bit(cap, rows[i].cap);
         host_u.read_reg(rows[i].ptr, d, ok);
         chk_byte(d, rows[i].rd);
      end
      // deselected module must stay silent and unchanged
      host_u.write_reg(1'b1, 8'h02, 8'h0f, ok);
      chk_bit(ok, 1'b0);
      wait_clk(8);
      chk_byte({4'h0, chan_dis}, 8'h00);
      // low-power pin caps power and shows in status
      lp_req = 1'b1;
      wait_clk(6);
      chk_bit(cap, 1'b1);
      host_u.read_reg(8'h00, d, ok);
      chk_byte(d, 8'h0e);
      lp_req = 1'b0;
      // attention cause found in flags, cleared by writing ones
      host_u.read_reg(8'h01, d, ok);
      chk_byte(d, 8'h01);
      wr(8'h01, 8'h01);
      chk_bit(attn_oe, 1'b0);
      fault = 4'h4;
      wait_clk(1);
      fault = 4'h0;
      wait_clk(3);
      chk_bit(attn_oe, 1'b1);
      host_u.read_reg(8'h01, d, ok);
      chk_byte(d, 8'h40);
      wr(8'h01, 8'h40);
      chk_bit(attn_oe, 1'b0);
      // reset pin low for exactly the minimum is not long enough
      wr(8'h02, 8'h03);
      mod_rst_n = 1'b0;
      wait_clk(MIN_R);
      mod_rst_n = 1'b1;
      wait_clk(10);
      chk_bit(nrdy, 1'b0);
      chk_byte({4'h0, chan_dis}, 8'h03);
      // a long low restores defaults and reports completion again
      mod_rst_n = 1'b0;
      wait_clk(MIN_R + 12);
      chk_bit(nrdy, 1'b1);
      chk_byte({4'h0, chan_dis}, 8'h0f);
      mod_rst_n = 1'b1;
      wait_ready();
      chk_bit(attn_oe, 1'b1);
      host_u.read_reg(8'h02, d, ok);
      chk_byte(d, 8'h00);
      complete_run();
   end
endmodule : pmsc_top_bench
